/* hw/dbh_alu.sv */
// Purpose: Decrement datapath with zero detect
// Assumes: Operand stable in the cycle the instruction is taken
// Notes:   Shared by both decrement forms
`timescale 1ns/1ps
`include "dbh_consts.svh"

module dbh_alu
  import dbh_pkg::*;
(
  // Datapath
  dbh_alu_if.alu bus
);

  always_comb
  begin
    bus.result  = dbh_dec(bus.operand);
    bus.is_zero = (dbh_dec(bus.operand) == `DBH_ZERO);
  end

endmodule

/* hw/dbh_alu_if.sv */
// Purpose: Carrier between the sequencer and the decrement datapath
// Assumes: Single clock, purely combinational datapath
// Notes:   None
`timescale 1ns/1ps

interface dbh_alu_if;
  import dbh_pkg::*;

  dbh_data_t operand;
  dbh_data_t result;
  logic      is_zero;

  modport seq (output operand, input result, input is_zero);
  modport alu (input operand, output result, output is_zero);
endinterface

/* hw/dbh_consts.svh */
// Purpose: Shared constants for the decrement, branch and halt execution block
// Assumes: Included by bare name; definitions only
// Notes:   Widths, encodings and counts used across files
//
// Operation
// - Decrement register to accumulator or back, sets zero
// - Skip form zero result discards following fetched instruction
// - Skip form takes one cycle, two when skipping
// - Skip form changes no status flag
// - Absolute jump loads 13-bit target, two cycles
`ifndef DBH_CONSTS_SVH
`define DBH_CONSTS_SVH

`define DBH_DATA_W  8
`define DBH_ADDR_W  8
`define DBH_PC_W    13
`define DBH_ONE     8'h01
`define DBH_ZERO    8'h00
`define DBH_PC_ZERO 13'h0000
`define DBH_SYNC_W  2

`endif

/* hw/dbh_exec.sv */
// Purpose: Executes decrement, decrement-skip, absolute jump and halt
// Assumes: Core presents decoded op with file register read data
// Notes:   Results are registered; ready drops for second cycles
`timescale 1ns/1ps
`include "dbh_consts.svh"

module dbh_exec
  import dbh_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_in,
  input  wire logic      resetn_in,
  // Decoded instruction
  input  wire logic      op_valid_in,
  input  wire dbh_op_e   op_in,
  input  wire dbh_addr_t file_addr_in,
  input  wire logic      dest_file_in,
  input  wire dbh_data_t operand_in,
  input  wire dbh_pc_t   target_in,
  output logic           ready_out,
  // Wake from enabled external interrupt, asynchronous
  input  wire logic      wake_in,
  // Accumulator write
  output logic           acc_we_out,
  output dbh_data_t      acc_data_out,
  // File register write
  output logic           file_we_out,
  output dbh_addr_t      file_addr_out,
  output dbh_data_t      file_data_out,
  // Zero flag
  output logic           zflag_we_out,
  output logic           zflag_out,
  // Program counter and fetch
  output logic           pc_load_out,
  output dbh_pc_t        pc_target_out,
  output logic           flush_out,
  // Core clock control
  output logic           core_clk_en_out,
  output logic           halted_out
);

  dbh_state_e             state_q;
  dbh_state_e             state_d;
  logic [`DBH_SYNC_W-1:0] wake_sync_q;
  logic                   wake_s;
  logic                   take;
  logic                   is_dec;
  logic                   is_skip;
  logic                   is_jump;
  logic                   is_halt;
  logic                   wr_acc;
  logic                   wr_file;
  dbh_alu_if              alu_bus ();

  dbh_alu u_alu
  (
    .bus (alu_bus)
  );

  assign alu_bus.operand = operand_in;

  // Two flops before the wake pin is looked at
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      wake_sync_q <= '0;
    else
      wake_sync_q <= {wake_sync_q[0], wake_in};
  end
  assign wake_s = wake_sync_q[1];

  // One decode helper so the four op strobes agree on what was taken; AST_JUMP and AST_HALT decode take and op_in directly
  function automatic logic op_hit(input logic taken, input dbh_op_e op, input dbh_op_e want);
    op_hit = taken && (op == want);
  endfunction

  assign ready_out = (state_q == DBH_ST_RUN);
  assign take      = op_valid_in && ready_out;
  assign is_dec    = op_hit(take, op_in, DBH_OP_DECREMENT_REGISTER);
  assign is_skip   = op_hit(take, op_in, DBH_OP_DECREMENT_SKIP_ON_NULL);
  assign is_jump   = op_hit(take, op_in, DBH_OP_JUMP_ABSOLUTE);
  assign is_halt   = op_hit(take, op_in, DBH_OP_HALT);
  assign wr_acc    = (is_dec || is_skip) && !dest_file_in;
  assign wr_file   = (is_dec || is_skip) && dest_file_in;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      DBH_ST_RUN:
      begin
        if (is_skip && alu_bus.is_zero)
          state_d = DBH_ST_SECOND;
        else if (is_jump)
          state_d = DBH_ST_SECOND;
        else if (is_halt)
          state_d = DBH_ST_HALT;
      end
      DBH_ST_SECOND:
        state_d = DBH_ST_RUN;
      DBH_ST_HALT:
        if (wake_s)
          state_d = DBH_ST_RUN;
      default:
        state_d = DBH_ST_RUN;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      state_q <= DBH_ST_RUN;
    else
      state_q <= state_d;
  end

  // Gating from the state flop keeps the enable glitch free
  assign core_clk_en_out = (state_q != DBH_ST_HALT);
  assign halted_out      = (state_q == DBH_ST_HALT);

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      acc_we_out    <= 1'b0;
      acc_data_out  <= `DBH_ZERO;
      file_we_out   <= 1'b0;
      file_addr_out <= `DBH_ZERO;
      file_data_out <= `DBH_ZERO;
    end
    else
    begin
      acc_we_out  <= wr_acc;
      file_we_out <= wr_file;
      if (wr_acc)
        acc_data_out <= alu_bus.result;
      if (wr_file)
      begin
        file_addr_out <= file_addr_in;
        file_data_out <= alu_bus.result;
      end
    end
  end

  // Only plain decrement touches the flag
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      zflag_we_out <= 1'b0;
      zflag_out    <= 1'b0;
    end
    else
    begin
      zflag_we_out <= is_dec;
      if (is_dec)
        zflag_out <= alu_bus.is_zero;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pc_load_out   <= 1'b0;
      pc_target_out <= `DBH_PC_ZERO;
      flush_out     <= 1'b0;
    end
    else
    begin
      pc_load_out <= is_jump;
      flush_out   <= (is_skip && alu_bus.is_zero) || is_jump;
      if (is_jump)
        pc_target_out <= target_in;
    end
  end

  AST_DEC_DEST: assert property (@(posedge clk_in) disable iff (!resetn_in)
    is_dec |=> (acc_we_out != file_we_out) && (file_we_out == $past(dest_file_in)) &&
               ((acc_we_out ? acc_data_out : file_data_out) == ($past(operand_in) - `DBH_ONE)))
    else $error("decrement result or destination wrong");

  AST_DEC_ZERO: assert property (@(posedge clk_in) disable iff (!resetn_in)
    is_dec |=> zflag_we_out && (zflag_out == ($past(operand_in) == `DBH_ONE)) && ready_out)
    else $error("decrement zero flag wrong");

  AST_SKIP_TAKEN: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (is_skip && operand_in == `DBH_ONE) |=> flush_out && !ready_out ##1 ready_out && !flush_out)
    else $error("skip did not insert exactly one idle cycle");

  AST_SKIP_NONE: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (is_skip && operand_in != `DBH_ONE) |=> !flush_out && ready_out)
    else $error("skip form stalled without a zero result");

  AST_SKIP_FLAGS: assert property (@(posedge clk_in) disable iff (!resetn_in)
    is_skip |=> !zflag_we_out && $stable(zflag_out))
    else $error("skip form touched the zero flag");

  AST_JUMP: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (take && op_in == DBH_OP_JUMP_ABSOLUTE) |=>
      pc_load_out && (pc_target_out == $past(target_in)) && !zflag_we_out && !ready_out ##1 ready_out)
    else $error("jump target or timing wrong");

  AST_HALT: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (take && op_in == DBH_OP_HALT) |=> !core_clk_en_out && halted_out && !zflag_we_out)
    else $error("halt did not stop the core clock");

  AST_WAKE: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (halted_out && wake_in) ##1 wake_in ##1 wake_in |-> ##[0:1] core_clk_en_out)
    else $error("core did not wake on interrupt");

  AST_BUSY_REFUSE: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (op_valid_in && !ready_out) |=> !acc_we_out && !file_we_out && !zflag_we_out && !pc_load_out && !flush_out)
    else $error("request taken while busy");

  AST_FLUSH_PULSE: assert property (@(posedge clk_in) disable iff (!resetn_in)
    flush_out |=> !flush_out && ready_out)
    else $error("discard lasted more than one cycle");

  AST_HALT_HOLD: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (halted_out && !wake_s) |=> halted_out && !core_clk_en_out)
    else $error("core left halt without a wake");

endmodule

/* hw/dbh_pkg.sv */
// Purpose: Types for the decrement, branch and halt execution block
// Assumes: dbh_consts.svh gives the widths
// Notes:   Decrement helper for the datapath
`include "dbh_consts.svh"

package dbh_pkg;

  typedef logic [`DBH_DATA_W-1:0] dbh_data_t;
  typedef logic [`DBH_ADDR_W-1:0] dbh_addr_t;
  typedef logic [`DBH_PC_W-1:0]   dbh_pc_t;

  typedef enum logic [2:0]
  {
    DBH_OP_NONE,
    DBH_OP_DECREMENT_REGISTER,
    DBH_OP_DECREMENT_SKIP_ON_NULL,
    DBH_OP_JUMP_ABSOLUTE,
    DBH_OP_HALT
  } dbh_op_e;

  typedef enum logic [1:0]
  {
    DBH_ST_RUN,
    DBH_ST_SECOND,
    DBH_ST_HALT
  } dbh_state_e;

  function automatic dbh_data_t dbh_dec(input dbh_data_t value);
    dbh_dec = value - `DBH_ONE;
  endfunction

endpackage

/* sim/testbench.sv */
// Purpose: Self-checking bench for the decrement, branch and halt block
// Assumes: Rule assertions live inside the design
// Notes:   Inputs move 1 ns after the rising edge
`timescale 1ns/1ps

module testbench
  import dbh_pkg::*;
;
  logic      clk_in = 1'b0;
  logic      resetn_in = 1'b0;
  logic      op_valid_in = 1'b0;
  dbh_op_e   op_in = DBH_OP_NONE;
  dbh_addr_t file_addr_in = 8'h3C;
  logic      dest_file_in = 1'b0;
  dbh_data_t operand_in = 8'h00;
  dbh_pc_t   target_in = 13'h0000;
  logic      wake_in = 1'b0;
  logic      ready_out, acc_we_out, file_we_out, zflag_we_out, zflag_out;
  logic      pc_load_out, flush_out, core_clk_en_out, halted_out;
  dbh_data_t acc_data_out, file_data_out;
  dbh_addr_t file_addr_out;
  dbh_pc_t   pc_target_out;
  int        mismatches = 0;
  int        checks = 0;

  dbh_exec dbh_exec_inst (.clk_in(clk_in), .resetn_in(resetn_in), .op_valid_in(op_valid_in),
    .op_in(op_in), .file_addr_in(file_addr_in), .dest_file_in(dest_file_in), .operand_in(operand_in),
    .target_in(target_in), .ready_out(ready_out), .wake_in(wake_in), .acc_we_out(acc_we_out),
    .acc_data_out(acc_data_out), .file_we_out(file_we_out), .file_addr_out(file_addr_out),
    .file_data_out(file_data_out), .zflag_we_out(zflag_we_out), .zflag_out(zflag_out),
    .pc_load_out(pc_load_out), .pc_target_out(pc_target_out), .flush_out(flush_out),
    .core_clk_en_out(core_clk_en_out), .halted_out(halted_out));

  always #12.5 clk_in = ~clk_in;

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Idle edge first so valid never falls and rises in one step; keep leaves a decrement pending
  task automatic issue(input dbh_op_e op, input dbh_data_t v, input logic d, input dbh_pc_t k,
                       input logic keep);
    @(posedge clk_in);
    #1;
    op_in = op;
    operand_in = v;
    dest_file_in = d;
    target_in = k;
    op_valid_in = 1'b1;
    @(posedge clk_in);
    #1;
    op_valid_in = keep;
    if (keep)
      op_in = DBH_OP_DECREMENT_REGISTER;
  endtask

  task automatic t_dec;
    issue(DBH_OP_NONE, 8'h10, 1'b1, 13'h0000, 1'b0);
    chk({acc_we_out, file_we_out, zflag_we_out, pc_load_out, flush_out, ready_out}, 6'h01);
    issue(DBH_OP_DECREMENT_REGISTER, 8'h23, 1'b0, 13'h0000, 1'b0);
    chk({acc_we_out, file_we_out, zflag_we_out, zflag_out, ready_out, acc_data_out}, {5'h15, 8'h22});
    issue(DBH_OP_DECREMENT_REGISTER, 8'h01, 1'b1, 13'h0000, 1'b0);
    chk({acc_we_out, file_we_out, zflag_we_out, zflag_out, file_data_out}, {4'h7, 8'h00});
    chk(file_addr_out, 8'h3C);
    issue(DBH_OP_DECREMENT_REGISTER, 8'h00, 1'b0, 13'h0000, 1'b0);
    chk({acc_we_out, zflag_we_out, zflag_out, acc_data_out}, {3'h6, 8'hFF});
    $display("decrement done");
  endtask

  // Zero flag is left low here, so a stray write of 1 shows
  task automatic t_skip;
    issue(DBH_OP_DECREMENT_SKIP_ON_NULL, 8'h05, 1'b1, 13'h0000, 1'b0);
    chk({file_we_out, zflag_we_out, flush_out, ready_out, file_data_out}, {4'h9, 8'h04});
    issue(DBH_OP_DECREMENT_SKIP_ON_NULL, 8'h01, 1'b0, 13'h0000, 1'b0);
    chk({acc_we_out, zflag_we_out, flush_out, ready_out, acc_data_out}, {4'hA, 8'h00});
    chk({zflag_we_out, zflag_out}, 2'b00);
    @(posedge clk_in);
    #1;
    chk({flush_out, ready_out, zflag_out}, 3'b010);
    $display("skip done");
  endtask

  // Held decrement is refused while busy, then taken once ready returns
  task automatic t_jump;
    issue(DBH_OP_JUMP_ABSOLUTE, 8'h00, 1'b0, 13'h1FFF, 1'b1);
    chk({pc_load_out, flush_out, ready_out, zflag_we_out, pc_target_out}, {4'hC, 13'h1FFF});
    @(posedge clk_in);
    #1;
    chk({acc_we_out, pc_load_out, flush_out, ready_out}, 4'h1);
    @(posedge clk_in);
    #1;
    op_valid_in = 1'b0;
    chk({acc_we_out, zflag_we_out, zflag_out, acc_data_out}, {3'h6, 8'hFF});
    $display("jump done");
  endtask

  task automatic t_halt;
    issue(DBH_OP_HALT, 8'h00, 1'b0, 13'h0000, 1'b0);
    chk({core_clk_en_out, halted_out, ready_out, zflag_we_out}, 4'h4);
    repeat (6) @(posedge clk_in);
    #1;
    chk({core_clk_en_out, halted_out, ready_out}, 3'b010);
    wake_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    wake_in = 1'b0;
    chk({core_clk_en_out, halted_out, ready_out}, 3'b101);
    issue(DBH_OP_DECREMENT_REGISTER, 8'h80, 1'b0, 13'h0000, 1'b0);
    chk({acc_we_out, acc_data_out}, {1'b1, 8'h7F});
    $display("halt done");
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run needs well under a hundred cycles
  initial
  begin
    #(25 * 2000);
    mismatches++;
    test_done();
  end

  initial
  begin
    repeat (10) @(posedge clk_in);
    #1;
    chk({ready_out, core_clk_en_out, halted_out, acc_we_out, file_we_out, pc_load_out, flush_out}, 7'h60);
    repeat (6) @(posedge clk_in);
    #1;
    resetn_in = 1'b1;
    t_dec();
    t_skip();
    t_jump();
    t_halt();
    test_done();
  end
endmodule
